// [design/iopic_core.sv]
// Contract
// [RULE_01] Cache flush: protection fault before intercept
// [RULE_02] Address watch arm: exceptions before intercept
// [RULE_03] Wait: exceptions, conditional, then unconditional
// [RULE_04] Both waits: low power picks conditional
// [RULE_05] Ext control write: intercept before fault
// [RULE_06] User counter read: exceptions before intercept
// [RULE_07] Hypervisor supplies aligned 12-Kbyte bitmap
// [RULE_08] Entry loads base, ignores low 12 bits
// [RULE_09] Bitmap end beyond max address: bad state
// [RULE_10] Bitmap bit n guards port n
// [RULE_11] Bitmap consulted only when trap enabled
// [RULE_12] Wide access intercepts if any bit set
// [RULE_13] Mode/privilege/task faults before port check
// [RULE_14] Port, address and operand width fields
// [RULE_15] Iterated and block transfer flags
// [RULE_16] Direction bit zero, reserved bits zero
// [RULE_17] Next instruction pointer saved in detail two
// [RULE_18] Segment field, data segment default
// [RULE_19] Block port read reports extra segment
// [RULE_20] Management irq on I/O encodes segment
// [RULE_21] Bitmap fetched by physical address
// [RULE_22] Trap disabled: ports never intercepted
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module iopic_core #(
    parameter int PA_WIDTH = 52
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Instruction request
    input wire logic i_req,
    input wire logic [3:0] i_op,
    input wire logic i_early_fault,
    input wire logic i_late_fault,
    input wire logic i_would_sleep,
    input wire logic [15:0] i_port,
    input wire logic [2:0] i_opw_onehot,
    input wire logic [2:0] i_addrw_onehot,
    input wire logic i_iterated,
    input wire logic i_block,
    input wire logic i_is_read,
    input wire logic i_seg_override,
    input wire logic [2:0] i_seg,
    input wire logic i_mgmt_irq,
    input wire logic [63:0] i_next_ip,
    input wire logic [63:0] i_base_field,
    // Bitmap fetch
    output logic o_map_rd,
    output logic [63:0] o_map_addr,
    input wire logic i_map_valid,
    input wire logic [7:0] i_map_byte,
    // Decision
    output logic o_done,
    output logic [3:0] o_result,
    output logic o_busy
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        iopic_pkg::iopic_state_type st;
        logic [6:0] ctrl;          // Intercept enables
        logic [63:0] base;         // Loaded map base
        logic [31:0] detail_one;   // Exit detail word
        logic [63:0] detail_two;   // Resume pointer
        logic [3:0] result;        // Last decision
        logic done;
        logic map_rd;
        logic [63:0] map_addr;
        logic [16:0] fetch_bit;    // Bit index of next byte to fetch
        logic [1:0] left;          // Fetches still to go
        logic hit;                 // Some covered bit was 1
        logic [16:0] end_bit; // Last covered bit, kept apart from the detail word
        logic busy; // Registered copy of st != idle
        logic [31:0] pend_detail;
        logic [63:0] pend_ip;
        logic late;                // Late fault held for after check
        logic [31:0] rdata;
    } iopic_state_struct_type;

    iopic_state_struct_type s_reg;
    iopic_state_struct_type s_next;

    // Byte count of the access from the one-hot operand width
    logic [2:0] nbytes;
    // Last covered port index, one bit wider for wrap past 0xffff
    logic [16:0] last_bit;
    // Bitmap mask of the covered bits in the fetched byte
    logic [7:0] want;
    logic [2:0] seg_eff;
    logic [31:0] detail;
    logic [63:0] map_end;

    always_comb
    begin
        nbytes = i_opw_onehot[2] ? 3'h4 : (i_opw_onehot[1] ? 3'h2 : 3'h1);
        last_bit = {1'b0, i_port} + {14'h0, nbytes} - 17'h1;
        // Default data segment unless overridden
        seg_eff = i_seg_override ? i_seg : iopic_pkg::SEG_DATA; // RULE_18
        if (i_block && i_is_read)
        begin
            seg_eff = iopic_pkg::SEG_EXTRA; // RULE_19
        end
        // Reserved bits 15:13 and 1 stay zero
        detail = iopic_pkg::DETAIL_RESET; // RULE_16
        detail[31:iopic_pkg::PORT_LSB] = i_port; // RULE_14
        detail[iopic_pkg::SEG_LSB +: 3] = seg_eff; // RULE_18 RULE_20
        detail[iopic_pkg::ADDR64_BIT] = i_addrw_onehot[2]; // RULE_14
        detail[iopic_pkg::ADDR32_BIT] = i_addrw_onehot[1];
        detail[iopic_pkg::ADDR16_BIT] = i_addrw_onehot[0];
        detail[iopic_pkg::OPW32_BIT] = i_opw_onehot[2];
        detail[iopic_pkg::OPW16_BIT] = i_opw_onehot[1];
        detail[iopic_pkg::OPW8_BIT] = i_opw_onehot[0];
        detail[iopic_pkg::ITER_BIT] = i_iterated; // RULE_15
        detail[iopic_pkg::BLOCK_BIT] = i_block; // RULE_15
        detail[iopic_pkg::DIR_BIT] = i_is_read; // RULE_16
        map_end = {i_base_field[63:iopic_pkg::PAGE_BITS], 12'h000} + iopic_pkg::MAP_LAST_OFS;
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.map_rd = 1'b0;
        s_next.rdata = 32'h0;
        want = 8'h0;
        // Register write: enables only; detail words are read-only
        if (i_reg_wr && i_reg_addr == iopic_pkg::REG_CTRL)
        begin
            s_next.ctrl = i_reg_wdata[6:0];
        end
        // Register read, answered the next cycle
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                iopic_pkg::REG_DETAIL_ONE: s_next.rdata = s_reg.detail_one;
                iopic_pkg::REG_DETAIL_TWO_LO: s_next.rdata = s_reg.detail_two[31:0];
                iopic_pkg::REG_DETAIL_TWO_HI: s_next.rdata = s_reg.detail_two[63:32];
                iopic_pkg::REG_BASE_LO: s_next.rdata = s_reg.base[31:0];
                iopic_pkg::REG_BASE_HI: s_next.rdata = s_reg.base[63:32];
                iopic_pkg::REG_RESULT: s_next.rdata = {28'h0, s_reg.result};
                iopic_pkg::REG_CTRL: s_next.rdata = {25'h0, s_reg.ctrl};
                default: s_next.rdata = 32'h0;
            endcase
        end
        case (s_reg.st)
            iopic_pkg::ST_IDLE:
            begin
                if (i_req)
                begin
                    s_next.done = 1'b1;
                    case (iopic_pkg::iopic_op_type'(i_op))
                        iopic_pkg::OP_CACHE_FLUSH, iopic_pkg::OP_CACHE_KEEP:
                        begin
                            // Fault wins over intercept
                            s_next.result = i_early_fault ? iopic_pkg::RES_EXCEPTION : // RULE_01
                                (s_reg.ctrl[iopic_pkg::CTRL_CACHE] ? iopic_pkg::RES_CACHE_EXIT
                                                                    : iopic_pkg::RES_EXECUTE);
                        end
                        iopic_pkg::OP_WATCH_ARM:
                        begin
                            s_next.result = (i_early_fault || i_late_fault) ? iopic_pkg::RES_EXCEPTION : // RULE_02
                                (s_reg.ctrl[iopic_pkg::CTRL_ARM] ? iopic_pkg::RES_ARM_EXIT
                                                                  : iopic_pkg::RES_EXECUTE);
                        end
                        iopic_pkg::OP_WATCH_WAIT, iopic_pkg::OP_WATCH_WAIT_EXT:
                        begin
                            // Conditional exit only when the wait would sleep
                            if (i_early_fault || i_late_fault)
                                s_next.result = iopic_pkg::RES_EXCEPTION; // RULE_03
                            else if (s_reg.ctrl[iopic_pkg::CTRL_WAIT_COND] && i_would_sleep)
                                s_next.result = iopic_pkg::RES_WAIT_COND_EXIT; // RULE_03 RULE_04
                            else if (s_reg.ctrl[iopic_pkg::CTRL_WAIT_UNCOND])
                                s_next.result = iopic_pkg::RES_WAIT_UNCOND_EXIT; // RULE_04
                            else
                                s_next.result = iopic_pkg::RES_EXECUTE;
                        end
                        iopic_pkg::OP_EXT_CTRL_WR:
                        begin
                            // Intercept wins over the fault here
                            s_next.result = s_reg.ctrl[iopic_pkg::CTRL_XCR] ? iopic_pkg::RES_XCR_EXIT : // RULE_05
                                (i_early_fault ? iopic_pkg::RES_EXCEPTION : iopic_pkg::RES_EXECUTE);
                        end
                        iopic_pkg::OP_USER_CNT_RD:
                        begin
                            s_next.result = (i_early_fault || i_late_fault) ? iopic_pkg::RES_EXCEPTION : // RULE_06
                                (s_reg.ctrl[iopic_pkg::CTRL_CNT] ? iopic_pkg::RES_CNT_EXIT
                                                                  : iopic_pkg::RES_EXECUTE);
                        end
                        iopic_pkg::OP_GUEST_ENTRY:
                        begin
                            // Low 12 bits of the supplied base are dropped
                            s_next.base = {i_base_field[63:iopic_pkg::PAGE_BITS], 12'h000}; // RULE_08
                            // Last map byte must sit below the top physical address
                            if (map_end[63:PA_WIDTH] != '0) // RULE_09
                                s_next.result = iopic_pkg::RES_BAD_STATE;
                            else
                                s_next.result = iopic_pkg::RES_ENTRY_OK;
                        end
                        iopic_pkg::OP_PORT:
                        begin
                            if (i_early_fault)
                            begin
                                s_next.result = iopic_pkg::RES_EXCEPTION; // RULE_13
                            end
                            else if (!s_reg.ctrl[iopic_pkg::CTRL_PORT_TRAP])
                            begin
                                // No bitmap look-up at all when trapping is off
                                s_next.result = i_late_fault ? iopic_pkg::RES_EXCEPTION // RULE_22 RULE_11
                                                             : iopic_pkg::RES_EXECUTE;
                            end
                            else
                            begin
                                // Wide access may span two map bytes
                                s_next.done = 1'b0;
                                s_next.st = iopic_pkg::ST_FETCH;
                                s_next.fetch_bit = {1'b0, i_port};
                                s_next.end_bit = last_bit;
                                s_next.left = (last_bit[16:3] != {1'b0, i_port[15:3]}) ? 2'h2 : 2'h1;
                                s_next.hit = 1'b0;
                                s_next.late = i_late_fault;
                                s_next.pend_detail = i_mgmt_irq ? {19'h0, seg_eff, 10'h0} : detail; // RULE_20
                                s_next.pend_ip = i_next_ip;
                            end
                        end
                        default:
                        begin
                            s_next.result = iopic_pkg::RES_NONE;
                        end
                    endcase
                end
            end
            iopic_pkg::ST_FETCH:
            begin
                // Byte address is base plus port over eight, physical
                s_next.map_rd = 1'b1; // RULE_21
                s_next.map_addr = s_reg.base + {50'h0, s_reg.fetch_bit[16:3]}; // RULE_10
                s_next.st = iopic_pkg::ST_WAIT;
            end
            iopic_pkg::ST_WAIT:
            begin
                if (i_map_valid)
                begin
                    // Mark every covered bit inside this byte
                    for (int b = 0; b < 8; b++)
                    begin
                        if ({s_reg.fetch_bit[16:3], 3'(b)} >= s_reg.fetch_bit &&
                            {s_reg.fetch_bit[16:3], 3'(b)} <= s_reg.end_bit)
                        begin
                            want[b] = 1'b1;
                        end
                    end
                    s_next.hit = s_reg.hit | ((i_map_byte & want) != 8'h0); // RULE_12
                    if (s_reg.left == 2'h2)
                    begin
                        s_next.left = 2'h1;
                        s_next.fetch_bit = {s_reg.fetch_bit[16:3] + 14'h1, 3'h0};
                        s_next.st = iopic_pkg::ST_FETCH;
                    end
                    else
                    begin
                        s_next.st = iopic_pkg::ST_IDLE;
                        s_next.done = 1'b1;
                        if (s_next.hit)
                        begin
                            // Port exit: detail words latched
                            s_next.result = iopic_pkg::RES_PORT_EXIT; // RULE_12
                            s_next.detail_one = s_reg.pend_detail; // RULE_14
                            s_next.detail_two = s_reg.pend_ip; // RULE_17
                        end
                        else
                        begin
                            // Remaining faults come after the check
                            s_next.result = s_reg.late ? iopic_pkg::RES_EXCEPTION // RULE_13
                                                       : iopic_pkg::RES_EXECUTE;
                        end
                    end
                end
            end
            default:
            begin
                s_next.st = iopic_pkg::ST_IDLE;
            end
        endcase
        s_next.busy = (s_next.st != iopic_pkg::ST_IDLE);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_reg_rdata = s_reg.rdata;
    assign o_map_rd = s_reg.map_rd;
    assign o_map_addr = s_reg.map_addr;
    assign o_done = s_reg.done;
    assign o_result = s_reg.result;
    assign o_busy = s_reg.busy;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_cache_order;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_early_fault && (i_op == 4'h2 || i_op == 4'h3)) |=> (o_done && o_result == 4'h1);
    endproperty
    a_cache_order: assert property (p_cache_order) else $error("cache flush fault lost"); // RULE_01

    property p_xcr_order;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_op == 4'h7 && s_reg.ctrl[5]) |=> (o_result == 4'h7);
    endproperty
    a_xcr_order: assert property (p_xcr_order) else $error("ext ctrl intercept not first"); // RULE_05

    property p_wait_cond;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_op == 4'h5 && !i_early_fault && !i_late_fault && s_reg.ctrl[3] && i_would_sleep)
        |=> (o_result == 4'h5);
    endproperty
    a_wait_cond: assert property (p_wait_cond) else $error("conditional wait exit missing"); // RULE_04

    property p_trap_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_op == 4'h1 && !s_reg.ctrl[0]) |=> (!o_busy && o_result != 4'h2);
    endproperty
    a_trap_off: assert property (p_trap_off) else $error("port trapped while disabled"); // RULE_22

    property p_fetch_bound;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_op == 4'h1 && s_reg.ctrl[0] && !i_early_fault)
        |=> ##1 (o_map_rd && o_map_addr == s_reg.base + ({48'h0, $past(i_port, 2)} >> 3));
    endproperty
    a_fetch_bound: assert property (p_fetch_bound) else $error("map fetch at wrong byte"); // RULE_10

    property p_exit_detail;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_done && o_result == 4'h2) |-> (s_reg.detail_one[15:13] == 3'h0 && s_reg.detail_one[1] == 1'b0);
    endproperty
    a_exit_detail: assert property (p_exit_detail) else $error("reserved detail bits set"); // RULE_16

    property p_base_low;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_op == 4'h9) |=> (s_reg.base[11:0] == 12'h000);
    endproperty
    a_base_low: assert property (p_base_low) else $error("base low bits kept"); // RULE_08

    property p_early_port;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_req && !o_busy && i_op == 4'h1 && i_early_fault) |=> (o_done && o_result == 4'h1 && !o_busy);
    endproperty
    a_early_port: assert property (p_early_port) else $error("early port fault not first"); // RULE_13

endmodule

`default_nettype wire

// [design/iopic_pkg.sv]
`default_nettype none
package iopic_pkg;

    // ****************************************************************
    // Exit detail word field positions
    // ****************************************************************
    localparam int PORT_LSB = 16;              // Port number, bits 31:16
    localparam int SEG_LSB = 10;               // Segment field, bits 12:10
    localparam int ADDR64_BIT = 9;
    localparam int ADDR32_BIT = 8;
    localparam int ADDR16_BIT = 7;
    localparam int OPW32_BIT = 6;
    localparam int OPW16_BIT = 5;
    localparam int OPW8_BIT = 4;
    localparam int ITER_BIT = 3;
    localparam int BLOCK_BIT = 2;
    localparam int DIR_BIT = 0;
    localparam logic [31:0] DETAIL_RESET = 32'h0000_0000;

    // ****************************************************************
    // Segment encodings and map geometry
    // ****************************************************************
    localparam logic [2:0] SEG_EXTRA = 3'h0;   // Extra segment code
    localparam logic [2:0] SEG_DATA = 3'h3;    // Data segment code (default)
    localparam int PAGE_BITS = 12;             // 4-Kbyte alignment
    localparam logic [63:0] MAP_LAST_OFS = 64'h0000_0000_0000_2000; // 64K+3 bits -> last byte

    // ****************************************************************
    // Operation codes and exit codes
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_PORT = 4'h1,
        OP_CACHE_FLUSH = 4'h2,
        OP_CACHE_KEEP = 4'h3,
        OP_WATCH_ARM = 4'h4,
        OP_WATCH_WAIT = 4'h5,
        OP_WATCH_WAIT_EXT = 4'h6,
        OP_EXT_CTRL_WR = 4'h7,
        OP_USER_CNT_RD = 4'h8,
        OP_GUEST_ENTRY = 4'h9
    } iopic_op_type;

    typedef enum logic [3:0] {
        RES_NONE = 4'h0,
        RES_EXCEPTION = 4'h1,
        RES_PORT_EXIT = 4'h2,
        RES_CACHE_EXIT = 4'h3,
        RES_ARM_EXIT = 4'h4,
        RES_WAIT_COND_EXIT = 4'h5,
        RES_WAIT_UNCOND_EXIT = 4'h6,
        RES_XCR_EXIT = 4'h7,
        RES_CNT_EXIT = 4'h8,
        RES_BAD_STATE = 4'h9,
        RES_EXECUTE = 4'ha,
        RES_ENTRY_OK = 4'hb
    } iopic_res_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT = 2'b10
    } iopic_state_type;

    // ****************************************************************
    // Register map of the plain register port
    // ****************************************************************
    localparam logic [3:0] REG_DETAIL_ONE = 4'h0;  // Exit detail word
    localparam logic [3:0] REG_DETAIL_TWO_LO = 4'h1;
    localparam logic [3:0] REG_DETAIL_TWO_HI = 4'h2;
    localparam logic [3:0] REG_BASE_LO = 4'h3;     // Loaded map base
    localparam logic [3:0] REG_BASE_HI = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h5;      // Last decision code
    localparam logic [3:0] REG_CTRL = 4'h6;        // Intercept enables
    localparam int CTRL_PORT_TRAP = 0;
    localparam int CTRL_CACHE = 1;
    localparam int CTRL_ARM = 2;
    localparam int CTRL_WAIT_COND = 3;
    localparam int CTRL_WAIT_UNCOND = 4;
    localparam int CTRL_XCR = 5;
    localparam int CTRL_CNT = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;

endpackage
`default_nettype wire

// [dv/tb_iopic_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_iopic_core;
    // ********************************************
    // Bench signals
    // ********************************************
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_req = 1'b0;
    logic i_early_fault = 1'b0, i_late_fault = 1'b0, i_would_sleep = 1'b0, i_iterated = 1'b0, i_mgmt_irq = 1'b0;
    logic i_block = 1'b0, i_is_read = 1'b0, i_seg_override = 1'b0, i_map_valid = 1'b0, rd_q = 1'b0;
    logic [3:0] i_reg_addr = 4'h0, i_op = 4'h0, o_result;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
    logic [15:0] i_port = 16'h0, p = 16'h0, tgt = 16'h0; // Tgt is the one intercepting port
    logic [2:0] i_opw_onehot = 3'h1, i_addrw_onehot = 3'h1, i_seg = 3'h0;
    logic [63:0] i_next_ip = 64'h0, i_base_field = 64'h0, o_map_addr;
    logic [63:0] base_exp = 64'h0000_0012_3456_7000;
    logic [7:0] i_map_byte = 8'h0;
    logic o_map_rd, o_done, o_busy;
    logic [63:0] exp_q[$]; // Expected results, oldest first
    int errors = 0, checks_done = 0;

    // Every input is driven by the bench
    iopic_core i_dut (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
        .i_req, .i_op, .i_early_fault, .i_late_fault, .i_would_sleep, .i_port, .i_opw_onehot,
        .i_addrw_onehot, .i_iterated, .i_block, .i_is_read, .i_seg_override, .i_seg, .i_mgmt_irq,
        .i_next_ip, .i_base_field, .o_map_rd, .o_map_addr, .i_map_valid, .i_map_byte, .o_done,
        .o_result, .o_busy);

    always #4 i_clk = ~i_clk;

    // ********************************************
    // Shared tasks
    // ********************************************
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
        begin
            checks_done++;
            if (seen !== want)
            begin
                errors++;
                $display("BAD %s expected %h seen %h", what, want, seen);
            end
        end
    endtask

    task automatic print_verdict();
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // One register access; a read notes its expected data
    task automatic reg_op(input logic rd, input logic [3:0] a, input logic [31:0] d);
        begin
            if (rd)
                exp_q.push_back({32'h0, d});
            @(posedge i_clk);
            i_reg_rd <= rd;
            i_reg_wr <= ~rd;
            i_reg_addr <= a;
            i_reg_wdata <= d;
            @(posedge i_clk);
            i_reg_rd <= 1'b0;
            i_reg_wr <= 1'b0;
        end
    endtask

    // Port request fields held beside the request
    task automatic setp(input logic [15:0] pt, input logic [5:0] w, input logic [3:0] m);
        begin
            @(posedge i_clk);
            i_port <= pt;
            {i_addrw_onehot, i_opw_onehot} <= w;
            {i_seg_override, i_iterated, i_block, i_is_read} <= m;
            i_seg <= 3'h5;
            i_next_ip <= {$urandom, $urandom};
        end
    endtask

    // Answers bitmap fetches from a map with only bit tgt set; checks fetch order
    task automatic serve();
        logic [63:0] a;
        int k;
        begin
            k = 0;
            repeat (40)
            begin
                @(negedge i_clk);
                if (o_map_rd === 1'b1)
                begin
                    a = o_map_addr - base_exp;
                    check("map_addr", o_map_addr, base_exp + i_port[15:3] + k);
                    k++;
                    @(posedge i_clk);
                    i_map_valid <= 1'b1;
                    i_map_byte <= (a == {51'h0, tgt[15:3]}) ? 8'h01 << tgt[2:0] : 8'h00;
                    @(posedge i_clk);
                    i_map_valid <= 1'b0;
                    i_map_byte <= ~i_map_byte; // Stale byte is never left on the lines
                end
            end
        end
    endtask

    task automatic go(input logic [3:0] op, input logic [2:0] f, input logic [15:0] t, input logic [3:0] res);
        begin
            exp_q.push_back({60'h0, res});
            tgt = t;
            @(posedge i_clk);
            i_req <= 1'b1;
            i_op <= op;
            {i_would_sleep, i_late_fault, i_early_fault} <= f;
            @(posedge i_clk);
            i_req <= 1'b0;
            serve();
        end
    endtask

    // ********************************************
    // Monitor, watchdog and main sequence
    // ********************************************
    always @(posedge i_clk)
        rd_q <= i_reg_rd;

    // Read data and decisions never coincide, since requests are serialised
    always @(negedge i_clk)
    begin
        if (rd_q === 1'b1)
            check("reg_rdata", {32'h0, o_reg_rdata}, exp_q.pop_front());
        else if (o_done === 1'b1)
            check("result", {60'h0, o_result}, exp_q.pop_front());
    end

    // Whole run is about 900 cycles
    initial
    begin
        repeat (5000) @(posedge i_clk);
        errors++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(43674));
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        reg_op(1, iopic_pkg::REG_CTRL, 32'h0);
        reg_op(1, 4'hf, 32'h0);
        i_base_field <= 64'h000f_ffff_ffff_e000; // Last byte lands exactly on the limit
        go(iopic_pkg::OP_GUEST_ENTRY, 3'h0, 16'h0, iopic_pkg::RES_BAD_STATE);
        @(posedge i_clk);
        i_base_field <= 64'h0000_0012_3456_7abc;
        go(iopic_pkg::OP_GUEST_ENTRY, 3'h0, 16'h0, iopic_pkg::RES_ENTRY_OK);
        reg_op(1, iopic_pkg::REG_BASE_LO, 32'h3456_7000);
        reg_op(1, iopic_pkg::REG_BASE_HI, 32'h0000_0012);
        p = (16'($urandom) & 16'hfff0) | 16'h0007; // Word access straddles two map bytes
        setp(p, 6'b010_010, 4'b1111);
        go(iopic_pkg::OP_PORT, 3'h0, p + 16'h1, iopic_pkg::RES_EXECUTE);
        reg_op(0, iopic_pkg::REG_CTRL, 32'h7f);
        reg_op(1, iopic_pkg::REG_CTRL, 32'h7f);
        go(iopic_pkg::OP_PORT, 3'h1, p + 16'h1, iopic_pkg::RES_EXCEPTION);
        go(iopic_pkg::OP_PORT, 3'h2, p + 16'h1, iopic_pkg::RES_PORT_EXIT);
        reg_op(1, iopic_pkg::REG_DETAIL_ONE, {p, 6'h00, 6'b010_010, 4'b1101});
        reg_op(1, iopic_pkg::REG_DETAIL_TWO_LO, i_next_ip[31:0]);
        reg_op(1, iopic_pkg::REG_DETAIL_TWO_HI, i_next_ip[63:32]);
        go(iopic_pkg::OP_PORT, 3'h2, p + 16'h2, iopic_pkg::RES_EXCEPTION);
        setp(p ^ 16'h0007, 6'b100_001, 4'b0010);
        go(iopic_pkg::OP_PORT, 3'h0, p ^ 16'h0006, iopic_pkg::RES_EXECUTE);
        go(iopic_pkg::OP_PORT, 3'h0, p ^ 16'h0007, iopic_pkg::RES_PORT_EXIT);
        reg_op(1, iopic_pkg::REG_DETAIL_ONE, {p ^ 16'h0007, 6'h03, 6'b100_001, 4'b0100});
        i_mgmt_irq <= 1'b1;
        go(iopic_pkg::OP_PORT, 3'h0, p ^ 16'h0007, iopic_pkg::RES_PORT_EXIT);
        reg_op(1, iopic_pkg::REG_DETAIL_ONE, 32'h0000_0c00);
        go(iopic_pkg::OP_CACHE_FLUSH, 3'h1, 16'h0, iopic_pkg::RES_EXCEPTION);
        go(iopic_pkg::OP_CACHE_KEEP, 3'h0, 16'h0, iopic_pkg::RES_CACHE_EXIT);
        go(iopic_pkg::OP_WATCH_ARM, 3'h2, 16'h0, iopic_pkg::RES_EXCEPTION);
        go(iopic_pkg::OP_WATCH_ARM, 3'h0, 16'h0, iopic_pkg::RES_ARM_EXIT);
        go(iopic_pkg::OP_WATCH_WAIT, 3'h6, 16'h0, iopic_pkg::RES_EXCEPTION);
        go(iopic_pkg::OP_WATCH_WAIT, 3'h4, 16'h0, iopic_pkg::RES_WAIT_COND_EXIT);
        go(iopic_pkg::OP_WATCH_WAIT_EXT, 3'h0, 16'h0, iopic_pkg::RES_WAIT_UNCOND_EXIT);
        go(iopic_pkg::OP_EXT_CTRL_WR, 3'h1, 16'h0, iopic_pkg::RES_XCR_EXIT);
        go(iopic_pkg::OP_USER_CNT_RD, 3'h2, 16'h0, iopic_pkg::RES_EXCEPTION);
        go(iopic_pkg::OP_USER_CNT_RD, 3'h0, 16'h0, iopic_pkg::RES_CNT_EXIT);
        reg_op(0, iopic_pkg::REG_CTRL, 32'h10);
        go(iopic_pkg::OP_WATCH_WAIT_EXT, 3'h4, 16'h0, iopic_pkg::RES_WAIT_UNCOND_EXIT);
        repeat (4) @(posedge i_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
